// file: hw/acch_consts.svh
`ifndef ACCH_CONSTS_SVH
`define ACCH_CONSTS_SVH

// channel code carried by every request and reply of this converter channel
`define ACCH_CHANNEL 8'h14

// command codes, newer revision
`define ACCH_V2_GO 8'h02
`define ACCH_V2_SEL_WR 8'h50
`define ACCH_V2_SEL_RD 8'h51
`define ACCH_V2_MASK_WR 8'h60
`define ACCH_V2_MASK_RD 8'h61
`define ACCH_V2_GAIN_WR 8'h10
`define ACCH_V2_GAIN_RD 8'h11
`define ACCH_V2_DATA_RD 8'h21
`define ACCH_V2_RAW_RD 8'h31
`define ACCH_V2_OFS_RD 8'h41

// command codes, older revision
`define ACCH_V1_GO 8'hB2
`define ACCH_V1_SEL_WR 8'h30
`define ACCH_V1_SEL_RD 8'h31
`define ACCH_V1_MASK_WR 8'h40
`define ACCH_V1_MASK_RD 8'h41

// payload size field values
`define ACCH_LEN_ONE 8'h01
`define ACCH_LEN_TWO 8'h02
`define ACCH_LEN_FOUR 8'h04

// reply flag byte values
`define ACCH_FLAG_OK 8'h00
`define ACCH_FLAG_BADCMD 8'h10
`define ACCH_FLAG_BUSY 8'h40

// reset values of the channel registers
`define ACCH_SEL_RESET 6'h00
`define ACCH_MASK_RESET 32'h00000000

// master register offsets on its software port
`define ACCH_OFS_CMD 4'h0
`define ACCH_OFS_TXDATA 4'h4
`define ACCH_OFS_RXDATA 4'h8
`define ACCH_OFS_STATUS 4'hC

`endif

// file: hw/acch_device.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "acch_consts.svh"
module acch_device #(
  parameter int REVISION = 2 // 1 older code map, 2 newer code map
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  acch_if.dev link, // request and reply packets
  output logic conv_start, // one-cycle start pulse to the converter core
  output logic [5:0] input_line_select, // selected input line
  output logic [31:0] pad_current_source_enable, // per-pad source enables
  output logic [15:0] gain_factor, // gain calibration factor
  output logic conv_busy, // a conversion is in progress
  input wire logic [15:0] fuse_gain, // production gain from fuses
  input wire logic conv_done, // one-cycle end of conversion pulse
  input wire logic [11:0] conv_corrected, // offset and gain corrected result
  input wire logic [11:0] conv_raw, // uncorrected result
  input wire logic [11:0] conv_offset, // offset measured in the conversion
  input wire logic conv_overflow // input exceeded full scale
);
  localparam bit IS_V2 = (REVISION == 2);

  // result word: value in bits 11:0, overflow in bit 12
  function automatic logic [31:0] pack_result(input logic [11:0] val, input logic ovf);
    return {19'h00000, ovf, val};
  endfunction : pack_result

  acch_pkg::acch_dev_state_e state_reg;
  acch_pkg::acch_dev_state_e state_next;
  logic [5:0] sel_reg;
  logic [31:0] mask_reg;
  logic [15:0] gain_reg;
  logic gain_loaded_reg;
  logic start_reg;
  logic done_pend_reg;
  logic [7:0] go_trn_reg;
  logic [11:0] latest_reg;
  logic [11:0] raw_reg;
  logic [11:0] ofs_reg;
  logic ovf_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_trn_reg;
  logic [7:0] rsp_len_reg;
  logic [7:0] rsp_flag_reg;
  logic [31:0] rsp_data_reg;

  // request decode against the chosen code map
  wire ours = link.req_valid && (link.req_ch == `ACCH_CHANNEL);
  wire [7:0] cmd = link.req_cmd;
  wire converting = (state_reg == acch_pkg::ACCH_DEV_CONV);
  wire hit_go = IS_V2 ? (cmd == `ACCH_V2_GO) : (cmd == `ACCH_V1_GO);
  wire hit_sel_wr = IS_V2 ? (cmd == `ACCH_V2_SEL_WR) : (cmd == `ACCH_V1_SEL_WR);
  wire hit_sel_rd = IS_V2 ? (cmd == `ACCH_V2_SEL_RD) : (cmd == `ACCH_V1_SEL_RD);
  wire hit_mask_wr = IS_V2 ? (cmd == `ACCH_V2_MASK_WR) : (cmd == `ACCH_V1_MASK_WR);
  wire hit_mask_rd = IS_V2 ? (cmd == `ACCH_V2_MASK_RD) : (cmd == `ACCH_V1_MASK_RD);
  wire hit_gain_wr = IS_V2 && (cmd == `ACCH_V2_GAIN_WR);
  wire hit_gain_rd = IS_V2 && (cmd == `ACCH_V2_GAIN_RD);
  wire hit_data_rd = IS_V2 && (cmd == `ACCH_V2_DATA_RD);
  wire hit_raw_rd = IS_V2 && (cmd == `ACCH_V2_RAW_RD);
  wire hit_ofs_rd = IS_V2 && (cmd == `ACCH_V2_OFS_RD);
  wire hit_write = hit_sel_wr || hit_mask_wr || hit_gain_wr;
  wire hit_read = hit_sel_rd || hit_mask_rd || hit_gain_rd || hit_data_rd || hit_raw_rd || hit_ofs_rd;
  wire known = hit_go || hit_write || hit_read;
  wire exec = ours && !converting && known;
  wire reject_busy = ours && converting;
  wire reject_bad = ours && !converting && !known;
  // the result waits for a cycle in which no request needs the reply slot
  wire send_result = converting && done_pend_reg && !ours;

  wire [7:0] len_write = IS_V2 ? `ACCH_LEN_ONE : `ACCH_LEN_TWO;
  wire [7:0] len_go = IS_V2 ? `ACCH_LEN_FOUR : `ACCH_LEN_TWO;
  // overflow only exists in the older map; the newer reply is 12 bits
  wire ovf_bit = !IS_V2 && ovf_reg;

  // read data selection, values in the low bytes
  wire [31:0] read_data =
    hit_sel_rd ? {26'h0000000, sel_reg} :
    hit_mask_rd ? mask_reg :
    hit_gain_rd ? {16'h0000, gain_reg} :
    hit_data_rd ? pack_result(latest_reg, 1'b0) :
    hit_raw_rd ? pack_result(raw_reg, 1'b0) :
    hit_ofs_rd ? pack_result(ofs_reg, 1'b0) :
    32'h00000000;

  // reply fields for this cycle
  wire rsp_fire = send_result || (ours && !(exec && hit_go));
  wire [7:0] rsp_trn_next = send_result ? go_trn_reg : link.req_trn;
  wire [7:0] rsp_len_next =
    send_result ? len_go :
    (exec && hit_read) ? `ACCH_LEN_FOUR :
    (exec && hit_write) ? len_write :
    `ACCH_LEN_ONE;
  wire [7:0] rsp_flag_next =
    reject_busy ? `ACCH_FLAG_BUSY :
    reject_bad ? `ACCH_FLAG_BADCMD :
    `ACCH_FLAG_OK;
  wire [31:0] rsp_data_next =
    send_result ? pack_result(latest_reg, ovf_bit) :
    (exec && hit_read) ? read_data :
    32'h00000000;

  // state sequencing: start enters conversion, sent result leaves it
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      acch_pkg::ACCH_DEV_IDLE: begin
        if (exec && hit_go) begin
          state_next = acch_pkg::ACCH_DEV_CONV;
        end
      end
      acch_pkg::ACCH_DEV_CONV: begin
        if (send_result) begin
          state_next = acch_pkg::ACCH_DEV_IDLE;
        end
      end
      default: begin
        state_next = acch_pkg::ACCH_DEV_IDLE;
      end
    endcase
  end

  // sequencer, start pulse and end-of-conversion bookkeeping
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= acch_pkg::ACCH_DEV_IDLE;
      start_reg <= 1'b0;
      done_pend_reg <= 1'b0;
      go_trn_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      start_reg <= exec && hit_go;
      if (exec && hit_go) begin
        go_trn_reg <= link.req_trn;
      end
      if (converting && conv_done) begin
        done_pend_reg <= 1'b1;
      end else if (send_result) begin
        done_pend_reg <= 1'b0;
      end
    end
  end

  // conversion results kept for the reply and later reads
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latest_reg <= 12'h000;
      raw_reg <= 12'h000;
      ofs_reg <= 12'h000;
      ovf_reg <= 1'b0;
    end else if (converting && conv_done) begin
      latest_reg <= conv_corrected;
      raw_reg <= conv_raw;
      ofs_reg <= conv_offset;
      ovf_reg <= conv_overflow;
    end
  end

  // selector and source mask; multiple set mask bits are not blocked
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_reg <= `ACCH_SEL_RESET;
      mask_reg <= `ACCH_MASK_RESET;
    end else begin
      if (exec && hit_sel_wr) begin
        sel_reg <= link.req_data[5:0];
      end
      if (exec && hit_mask_wr) begin
        mask_reg <= link.req_data;
      end
    end
  end

  // gain: fuse value taken in the first cycle after reset, writes override
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gain_loaded_reg <= 1'b0;
      gain_reg <= 16'h0000;
    end else if (!gain_loaded_reg) begin
      gain_loaded_reg <= 1'b1;
      gain_reg <= fuse_gain;
    end else if (exec && hit_gain_wr) begin
      gain_reg <= link.req_data[15:0];
    end
  end

  // reply register: one reply per cycle at most
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_trn_reg <= 8'h00;
      rsp_len_reg <= 8'h00;
      rsp_flag_reg <= 8'h00;
      rsp_data_reg <= 32'h00000000;
    end else begin
      rsp_valid_reg <= rsp_fire;
      rsp_trn_reg <= rsp_trn_next;
      rsp_len_reg <= rsp_len_next;
      rsp_flag_reg <= rsp_flag_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  // outputs straight from flops, except the reply channel, which is the constant channel code
  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_ch = `ACCH_CHANNEL;
  assign link.rsp_trn = rsp_trn_reg;
  assign link.rsp_len = rsp_len_reg;
  assign link.rsp_flag = rsp_flag_reg;
  assign link.rsp_data = rsp_data_reg;
  assign conv_start = start_reg;
  assign input_line_select = sel_reg;
  assign pad_current_source_enable = mask_reg;
  assign gain_factor = gain_reg;
  assign conv_busy = state_reg[1];
endmodule : acch_device
`default_nettype wire

// file: hw/acch_if.sv
`timescale 1ns/1ns
`default_nettype none
interface acch_if (
  input wire logic core_clk // shared core clock
);
  logic req_valid;
  acch_pkg::acch_byte_t req_ch;
  acch_pkg::acch_byte_t req_trn;
  acch_pkg::acch_byte_t req_len;
  acch_pkg::acch_byte_t req_cmd;
  logic [31:0] req_data;
  logic rsp_valid;
  acch_pkg::acch_byte_t rsp_ch;
  acch_pkg::acch_byte_t rsp_trn;
  acch_pkg::acch_byte_t rsp_len;
  acch_pkg::acch_byte_t rsp_flag;
  logic [31:0] rsp_data;

  modport dev (
    input req_valid, req_ch, req_trn, req_len, req_cmd, req_data,
    output rsp_valid, rsp_ch, rsp_trn, rsp_len, rsp_flag, rsp_data
  );
  modport mst (
    output req_valid, req_ch, req_trn, req_len, req_cmd, req_data,
    input rsp_valid, rsp_ch, rsp_trn, rsp_len, rsp_flag, rsp_data
  );
endinterface : acch_if
`default_nettype wire

// file: hw/acch_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "acch_consts.svh"
module acch_master (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  acch_if.mst link, // request and reply packets
  input wire logic [3:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata // read data, cycle after rd
);
  acch_pkg::acch_mst_state_e state_reg;
  logic [31:0] txdata_reg;
  logic [7:0] trn_reg;
  logic req_valid_reg;
  logic [7:0] req_trn_reg;
  logic [7:0] req_len_reg;
  logic [7:0] req_cmd_reg;
  logic [31:0] req_data_reg;
  logic ready_reg;
  logic [7:0] got_trn_reg;
  logic [7:0] got_len_reg;
  logic [7:0] got_flag_reg;
  logic [31:0] got_data_reg;
  logic [31:0] rdata_reg;

  // software port decode
  wire waiting = (state_reg == acch_pkg::ACCH_MST_WAIT);
  wire launch = wr && (addr == `ACCH_OFS_CMD) && !waiting;
  wire match = waiting && link.rsp_valid && (link.rsp_ch == `ACCH_CHANNEL) && (link.rsp_trn == req_trn_reg);
  wire clear_ready = rd && (addr == `ACCH_OFS_RXDATA);
  wire [31:0] status_word = {got_trn_reg, got_len_reg, got_flag_reg, 6'h00, waiting, ready_reg};
  wire [31:0] read_mux =
    (addr == `ACCH_OFS_TXDATA) ? txdata_reg :
    (addr == `ACCH_OFS_RXDATA) ? got_data_reg :
    (addr == `ACCH_OFS_STATUS) ? status_word :
    32'h00000000;

  // request launch and reply wait
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= acch_pkg::ACCH_MST_IDLE;
      trn_reg <= 8'h01;
      req_valid_reg <= 1'b0;
      req_trn_reg <= 8'h00;
      req_len_reg <= 8'h00;
      req_cmd_reg <= 8'h00;
      req_data_reg <= 32'h00000000;
    end else begin
      req_valid_reg <= launch;
      if (launch) begin
        state_reg <= acch_pkg::ACCH_MST_WAIT;
        trn_reg <= trn_reg + 8'h01;
        req_trn_reg <= trn_reg;
        req_cmd_reg <= wdata[7:0];
        req_len_reg <= wdata[15:8];
        req_data_reg <= txdata_reg;
      end else if (match) begin
        state_reg <= acch_pkg::ACCH_MST_IDLE;
      end
    end
  end

  // reply capture; a new reply wins over a clearing read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txdata_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      got_trn_reg <= 8'h00;
      got_len_reg <= 8'h00;
      got_flag_reg <= 8'h00;
      got_data_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
    end else begin
      if (wr && (addr == `ACCH_OFS_TXDATA)) begin
        txdata_reg <= wdata;
      end
      if (match) begin
        ready_reg <= 1'b1;
        got_trn_reg <= link.rsp_trn;
        got_len_reg <= link.rsp_len;
        got_flag_reg <= link.rsp_flag;
        got_data_reg <= link.rsp_data;
      end else if (clear_ready) begin
        ready_reg <= 1'b0;
      end
      rdata_reg <= rd ? read_mux : 32'h00000000;
    end
  end

  assign link.req_valid = req_valid_reg;
  assign link.req_ch = `ACCH_CHANNEL;
  assign link.req_trn = req_trn_reg;
  assign link.req_len = req_len_reg;
  assign link.req_cmd = req_cmd_reg;
  assign link.req_data = req_data_reg;
  assign rdata = rdata_reg;
endmodule : acch_master
`default_nettype wire

// file: hw/acch_pkg.sv
package acch_pkg;
  // device sequencing: idle, or converting until the result reply is out
  typedef enum logic [1:0] {
    ACCH_DEV_IDLE = 2'b01,
    ACCH_DEV_CONV = 2'b10
  } acch_dev_state_e;

  // master sequencing: idle, or waiting for the reply of its request
  typedef enum logic [1:0] {
    ACCH_MST_IDLE = 2'b01,
    ACCH_MST_WAIT = 2'b10
  } acch_mst_state_e;

  typedef logic [7:0] acch_byte_t;
endpackage : acch_pkg

// file: sim/acch_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "acch_consts.svh"
module acch_link_asserts (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic req_valid, // request strobe
  input wire acch_pkg::acch_byte_t req_ch, // request channel
  input wire acch_pkg::acch_byte_t req_trn, // request transaction
  input wire acch_pkg::acch_byte_t req_cmd, // request command
  input wire logic rsp_valid, // reply strobe
  input wire acch_pkg::acch_byte_t rsp_ch, // reply channel
  input wire acch_pkg::acch_byte_t rsp_trn, // reply transaction
  input wire acch_pkg::acch_byte_t rsp_len, // reply size
  input wire acch_pkg::acch_byte_t rsp_flag, // reply flag
  input wire logic [31:0] rsp_data // reply payload
);
  logic conv_reg;
  logic prev_reg;
  wire take;
  wire is_go;
  wire is_wr;
  wire is_rd;
  // request decode for the newer code map
  assign take = req_valid && req_ch == `ACCH_CHANNEL;
  assign is_go = take && !conv_reg && req_cmd == `ACCH_V2_GO;
  assign is_wr = take && !conv_reg && req_cmd inside {8'h50, 8'h60, 8'h10};
  assign is_rd = take && !conv_reg && req_cmd inside {8'h51, 8'h61, 8'h11, 8'h21, 8'h31, 8'h41};
  // conversion in flight, seen from the link alone; result reply never comes in the cycle right after a request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      conv_reg <= is_go || (conv_reg && !(rsp_valid && !prev_reg));
      prev_reg <= take;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_go_start;
    is_go;
  endsequence
  sequence s_result;
    rsp_valid && !prev_reg;
  endsequence
  property p_req_ch; req_valid |-> req_ch == `ACCH_CHANNEL; endproperty
  a_req_ch: assert property (p_req_ch) else $error("request channel code wrong");
  property p_rsp_ch; rsp_valid |-> rsp_ch == `ACCH_CHANNEL; endproperty
  a_rsp_ch: assert property (p_rsp_ch) else $error("reply channel code wrong");
  property p_prompt; take && !is_go |=> rsp_valid && rsp_trn == $past(req_trn); endproperty
  a_prompt: assert property (p_prompt) else $error("no prompt reply with same transaction");
  property p_go_quiet; s_go_start |=> !rsp_valid; endproperty
  a_go_quiet: assert property (p_go_quiet) else $error("start answered before conversion end");
  property p_write_ack; is_wr |=> rsp_len == 8'h01 && rsp_flag == 8'h00; endproperty
  a_write_ack: assert property (p_write_ack) else $error("write reply malformed");
  property p_read_len; is_rd |=> rsp_len == 8'h04 && rsp_flag == 8'h00; endproperty
  a_read_len: assert property (p_read_len) else $error("read reply malformed");
  property p_badcmd; take && !conv_reg && !is_go && !is_wr && !is_rd |=> rsp_flag == 8'h10; endproperty
  a_badcmd: assert property (p_badcmd) else $error("unknown code not flagged");
  property p_result; s_result |-> rsp_len == 8'h04 && rsp_data[31:12] == 20'h00000; endproperty
  a_result: assert property (p_result) else $error("result reply malformed");
  property p_sel_width; is_rd && req_cmd == 8'h51 |=> rsp_data[31:6] == 26'h0000000; endproperty
  a_sel_width: assert property (p_sel_width) else $error("selector read too wide");
endmodule : acch_link_asserts
`default_nettype wire

// file: sim/adc_channel_command_handler_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "acch_consts.svh"
module adc_channel_command_handler_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic done = 1'b0;
  logic [11:0] corr = 12'h000;
  logic [11:0] raw = 12'h000;
  logic [11:0] ofs = 12'h000;
  logic ovf = 1'b0;
  logic [15:0] fuse = 16'h5A3C;
  logic start_a;
  logic [5:0] sel_a;
  logic [5:0] sel_b;
  logic [31:0] mask_a;
  logic [31:0] mask_b;
  logic busy_b;
  logic [15:0] gain_a;
  logic [5:0] go_line = 6'h00;
  logic [31:0] st;
  logic [31:0] got;
  int num_errors = 0;
  int total_checks = 0;
  acch_if lk_a (.core_clk(core_clk));
  acch_if lk_b (.core_clk(core_clk));
  acch_device #(.REVISION(2)) acch_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(lk_a.dev),
    .conv_start(start_a), .input_line_select(sel_a), .pad_current_source_enable(mask_a), .gain_factor(gain_a),
    .conv_busy(), .fuse_gain(fuse), .conv_done(done), .conv_corrected(corr), .conv_raw(raw), .conv_offset(ofs),
    .conv_overflow(ovf));
  acch_master acch_master_inst (.core_clk(core_clk), .rst_n(rst_n), .link(lk_a.mst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  acch_device #(.REVISION(1)) acch_device_v1_inst (.core_clk(core_clk), .rst_n(rst_n), .link(lk_b.dev),
    .conv_start(), .input_line_select(sel_b), .pad_current_source_enable(mask_b), .gain_factor(), .conv_busy(busy_b),
    .fuse_gain(fuse), .conv_done(done), .conv_corrected(corr), .conv_raw(raw), .conv_offset(ofs),
    .conv_overflow(ovf));
  acch_link_asserts acch_link_asserts_inst (.core_clk(core_clk), .rst_n(rst_n), .req_valid(lk_a.req_valid),
    .req_ch(lk_a.req_ch), .req_trn(lk_a.req_trn), .req_cmd(lk_a.req_cmd), .rsp_valid(lk_a.rsp_valid),
    .rsp_ch(lk_a.rsp_ch), .rsp_trn(lk_a.rsp_trn), .rsp_len(lk_a.rsp_len), .rsp_flag(lk_a.rsp_flag),
    .rsp_data(lk_a.rsp_data));
  // clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // line selected when the converter is started
  always @(posedge core_clk) begin
    if (start_a === 1'b1) go_line <= sel_a;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task conclude;
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // request through the master, then poll its status for the reply
  task mreq(input logic [7:0] op, input logic [31:0] tx, input logic [7:0] len, input logic [7:0] flag,
    input logic [31:0] d, input logic dk);
    int i;
    wr_reg(`ACCH_OFS_TXDATA, tx);
    wr_reg(`ACCH_OFS_CMD, {16'h0000, (op[0] ? `ACCH_LEN_ONE : `ACCH_LEN_FOUR), op});
    if (op == `ACCH_V2_GO) conv(12'h7E5, 12'h123, 12'h045, 1'b1);
    st = 32'h00000000;
    for (i = 0; i < 50 && st[0] !== 1'b1; i++) rd_reg(`ACCH_OFS_STATUS, st);
    if (st[0] !== 1'b1) begin
      chk("ready", 32'h00000001, st);
      conclude();
    end
    chk("len", {24'h000000, len}, {24'h000000, st[23:16]});
    chk("flag", {24'h000000, flag}, {24'h000000, st[15:8]});
    rd_reg(`ACCH_OFS_RXDATA, got);
    if (dk) chk("data", d, got);
  endtask : mreq
  task conv(input logic [11:0] c, input logic [11:0] r, input logic [11:0] o, input logic v);
    repeat (3) @(posedge core_clk);
    done <= 1'b1;
    corr <= c;
    raw <= r;
    ofs <= o;
    ovf <= v;
    @(posedge core_clk);
    done <= 1'b0;
  endtask : conv
  task dchk(input logic [7:0] transaction_id_field, input logic rsp, input logic [7:0] len, input logic [7:0] flag,
    input logic [31:0] d, input logic dk);
    chk("rsp", {31'h0, rsp}, {31'h0, lk_b.rsp_valid});
    if (rsp) chk("trn", {24'h000000, transaction_id_field}, {24'h000000, lk_b.rsp_trn});
    if (rsp) chk("len", {24'h000000, len}, {24'h000000, lk_b.rsp_len});
    if (rsp) chk("flag", {24'h000000, flag}, {24'h000000, lk_b.rsp_flag});
    if (rsp && dk) chk("data", d, lk_b.rsp_data);
  endtask : dchk
  // request driven straight onto the older device's link
  task dreq(input logic [7:0] op, input logic [31:0] tx, input logic rsp, input logic [7:0] len,
    input logic [7:0] flag, input logic [31:0] d, input logic dk);
    @(posedge core_clk);
    lk_b.req_valid <= 1'b1;
    lk_b.req_cmd <= op;
    lk_b.req_data <= tx;
    lk_b.req_trn <= lk_b.req_trn + 8'h01;
    lk_b.req_len <= op[0] ? `ACCH_LEN_ONE : `ACCH_LEN_FOUR;
    @(posedge core_clk);
    lk_b.req_valid <= 1'b0;
    #1 dchk(lk_b.req_trn, rsp, len, flag, d, dk);
  endtask : dreq
  initial begin
    int i;
    lk_b.req_valid = 1'b0;
    lk_b.req_ch = `ACCH_CHANNEL;
    lk_b.req_trn = 8'h00;
    lk_b.req_len = `ACCH_LEN_FOUR;
    lk_b.req_cmd = 8'h00;
    lk_b.req_data = 32'h00000000;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_reg(4'h2, got);
    chk("unmapped", 32'h00000000, got);
    mreq(`ACCH_V2_SEL_RD, 32'h0, 8'h04, 8'h00, 32'h00000000, 1'b1);
    mreq(`ACCH_V2_MASK_RD, 32'h0, 8'h04, 8'h00, 32'h00000000, 1'b1);
    mreq(`ACCH_V2_GAIN_RD, 32'h0, 8'h04, 8'h00, 32'h00005A3C, 1'b1);
    mreq(`ACCH_V2_SEL_WR, 32'h1F, 8'h01, 8'h00, 32'h0, 1'b0);
    mreq(`ACCH_V2_SEL_RD, 32'h0, 8'h04, 8'h00, 32'h0000001F, 1'b1);
    mreq(`ACCH_V2_MASK_WR, 32'h40000000, 8'h01, 8'h00, 32'h0, 1'b0);
    mreq(`ACCH_V2_MASK_RD, 32'h0, 8'h04, 8'h00, 32'h40000000, 1'b1);
    mreq(`ACCH_V2_GAIN_WR, 32'h1234, 8'h01, 8'h00, 32'h0, 1'b0);
    mreq(`ACCH_V2_GAIN_RD, 32'h0, 8'h04, 8'h00, 32'h00001234, 1'b1);
    mreq(`ACCH_V2_GO, 32'h1, 8'h04, 8'h00, 32'h000007E5, 1'b1);
    chk("line", 32'h0000001F, {26'h0, go_line});
    mreq(`ACCH_V2_DATA_RD, 32'h0, 8'h04, 8'h00, 32'h000007E5, 1'b1);
    mreq(`ACCH_V2_RAW_RD, 32'h0, 8'h04, 8'h00, 32'h00000123, 1'b1);
    mreq(`ACCH_V2_OFS_RD, 32'h0, 8'h04, 8'h00, 32'h00000045, 1'b1);
    mreq(`ACCH_V1_SEL_WR, 32'h0, 8'h01, 8'h10, 32'h0, 1'b0);
    chk("mask_a", 32'h40000000, mask_a);
    chk("gain_a", 32'h00001234, {16'h0, gain_a});
    dreq(`ACCH_V1_SEL_RD, 32'h0, 1'b1, 8'h04, 8'h00, 32'h0, 1'b1);
    dreq(`ACCH_V1_MASK_RD, 32'h0, 1'b1, 8'h04, 8'h00, 32'h0, 1'b1);
    dreq(`ACCH_V1_SEL_WR, 32'h2A, 1'b1, 8'h02, 8'h00, 32'h0, 1'b0);
    dreq(`ACCH_V1_SEL_RD, 32'h0, 1'b1, 8'h04, 8'h00, 32'h2A, 1'b1);
    dreq(`ACCH_V1_MASK_WR, 32'h8, 1'b1, 8'h02, 8'h00, 32'h0, 1'b0);
    dreq(`ACCH_V1_MASK_RD, 32'h0, 1'b1, 8'h04, 8'h00, 32'h8, 1'b1);
    dreq(`ACCH_V2_GAIN_RD, 32'h0, 1'b1, 8'h01, 8'h10, 32'h0, 1'b0);
    dreq(`ACCH_V1_GO, 32'h0, 1'b0, 8'h00, 8'h00, 32'h0, 1'b0);
    dreq(`ACCH_V1_SEL_WR, 32'h3, 1'b1, 8'h01, 8'h40, 32'h0, 1'b1);
    chk("busy_b", 32'h00000001, {31'h0, busy_b});
    conv(12'hABC, 12'h0, 12'h0, 1'b1);
    for (i = 0; i < 10 && lk_b.rsp_valid !== 1'b1; i++) @(posedge core_clk) #1;
    dchk(lk_b.req_trn - 8'h01, 1'b1, 8'h02, 8'h00, 32'h00001ABC, 1'b1);
    chk("busy_b", 32'h00000000, {31'h0, busy_b});
    chk("sel_b", 32'h0000002A, {26'h0, sel_b});
    chk("mask_b", 32'h00000008, mask_b);
    conclude();
  end
endmodule : adc_channel_command_handler_tb
`default_nettype wire
